/* File: verilog/eilo_top.sv */
// indicator lamp output ports with AHB-Lite register access
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RQ1: six ports, function and polarity, reset defaults
// RQ2: function 20 on coolant temp stop, unprotected
// RQ3: ignition on grounds bulb-check functions and lamps
// RQ4: function 22 on crankcase pressure stop
// RQ5: function 19 with check lamp when protected
// RQ6: function 19 on oil temp stop, unprotected
// RQ7: function 23 on coolant pressure stop
// RQ8: function 3 on low supply voltage
// RQ9: function 18 on oil pressure stop
// RQ10: function 26 toggles each half second counting
// RQ11: function 26 steady once idle active
// RQ12: function 5 in governor pressure mode
// RQ13: function 44 on selected critical fault subset
// RQ14: service-now lamp on any stop fault
// RQ15: lamp selection never changes protection reaction
// RQ16: check lamp can act as service-now
// RQ17: log fault on function 26 port diagnostics
// RQ18: log fault codes for each lamp condition
// RQ19: polarity applied before the low-side switch
// RQ20: unknown function number leaves port open
module eilo_top #(
  parameter int unsigned HALF_SEC_CYC = eilo_pkg::HALF_SEC_CYC,
  parameter int unsigned BULB_CYC = eilo_pkg::BULB_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic COOLANT_TEMP_STOP,
  input wire logic CRANK_PRESS_STOP,
  input wire logic OIL_TEMP_CHECK,
  input wire logic OIL_TEMP_STOP,
  input wire logic COOLANT_PRESS_STOP,
  input wire logic OIL_PRESS_STOP,
  input wire logic SUPPLY_LOW,
  input wire logic IGNITION_ON,
  input wire logic SYS_INIT_DONE,
  input wire logic IDLE_COUNTING,
  input wire logic IDLE_ACTIVE,
  input wire logic GOV_PRESS_MODE,
  input wire logic STOP_FAULT,
  input wire logic [7:0] CRIT_FAULTS,
  input wire logic [5:0] PORT_OPEN,
  input wire logic [5:0] PORT_SHORT,
  output logic [5:0] PORT_GND,
  output logic CHECK_ENGINE_LAMP,
  output logic STOP_ENGINE_LAMP,
  output logic SERVICE_NOW_LAMP
);

  localparam int NP = eilo_pkg::NUM_PORTS;
  localparam int SYNC_W = 33;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: every lamp-side input pin passes two flops; the AHB-Lite inputs are not synchronised
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] raw_in;

  assign raw_in = {PORT_SHORT, PORT_OPEN, CRIT_FAULTS, STOP_FAULT, GOV_PRESS_MODE,
                   IDLE_ACTIVE, IDLE_COUNTING, SYS_INIT_DONE, IGNITION_ON, SUPPLY_LOW,
                   OIL_PRESS_STOP, COOLANT_PRESS_STOP, OIL_TEMP_STOP, OIL_TEMP_CHECK,
                   CRANK_PRESS_STOP, COOLANT_TEMP_STOP};

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic cool_temp_s, crank_s, oil_chk_s, oil_stop_s, cool_press_s, oil_press_s;
  logic supply_s, ign_s, init_s, idle_cnt_s, idle_act_s, gov_s, stop_fault_s;
  logic [7:0] crit_s;
  logic [5:0] open_s;
  logic [5:0] short_s;

  assign cool_temp_s = sync2_reg[0];
  assign crank_s = sync2_reg[1];
  assign oil_chk_s = sync2_reg[2];
  assign oil_stop_s = sync2_reg[3];
  assign cool_press_s = sync2_reg[4];
  assign oil_press_s = sync2_reg[5];
  assign supply_s = sync2_reg[6];
  assign ign_s = sync2_reg[7];
  assign init_s = sync2_reg[8];
  assign idle_cnt_s = sync2_reg[9];
  assign idle_act_s = sync2_reg[10];
  assign gov_s = sync2_reg[11];
  assign stop_fault_s = sync2_reg[12];
  assign crit_s = sync2_reg[20:13];
  assign open_s = sync2_reg[26:21];
  assign short_s = sync2_reg[32:27];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] func_reg [NP];
  logic [NP-1:0] pol_reg;
  logic [31:0] ctrl_reg;
  logic [7:0] svc_mask_reg;
  logic [eilo_pkg::LOG_W-1:0] log_reg;
  logic overtemp_protection_enable;
  logic check_as_service;
  logic [7:0] lamp_config_code;
  assign overtemp_protection_enable = ctrl_reg[eilo_pkg::CTRL_OVERTEMP_BIT];
  assign check_as_service = ctrl_reg[eilo_pkg::CTRL_CHECK_AS_SVC_BIT];
  assign lamp_config_code = ctrl_reg[eilo_pkg::CTRL_LCC_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic wr_pend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] rdata_next;
  logic addr_phase;

  assign addr_phase = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend_reg <= addr_phase && HWRITE;
      if (addr_phase) begin
        waddr_reg <= HADDR[7:0];
      end
      // read data is captured at the address phase, so it stands in the data phase
      if (addr_phase && !HWRITE) begin
        HRDATA <= rdata_next;
      end
    end
  end

  // unmapped addresses and upper address bits read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (HADDR[31:8] == 24'h00_0000) begin
      for (int i = 0; i < NP; i++) begin
        if (HADDR[7:0] == eilo_pkg::A_PORT0 + 8'(4 * i)) begin
          rdata_next = {23'h00_0000, pol_reg[i], func_reg[i]};
        end
      end
      unique case (HADDR[7:0])
        eilo_pkg::A_CTRL: rdata_next = ctrl_reg;
        eilo_pkg::A_SVC_MASK: rdata_next = {24'h00_0000, svc_mask_reg};
        eilo_pkg::A_STATUS: rdata_next = {19'h0_0000, sync2_reg[12:0]};
        eilo_pkg::A_FAULT_LOG: rdata_next = {25'h000_0000, log_reg};
        default: ;
      endcase
    end
  end

  logic wr_hit;
  assign wr_hit = wr_pend_reg;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < NP; i++) begin
        func_reg[i] <= eilo_pkg::PORT_FUNC_RST[8*i +: 8];  // RQ1
      end
      pol_reg <= eilo_pkg::PORT_POL_RST;
    end else if (wr_hit) begin
      for (int i = 0; i < NP; i++) begin
        if (waddr_reg == eilo_pkg::A_PORT0 + 8'(4 * i)) begin
          func_reg[i] <= HWDATA[7:0];  // RQ1
          pol_reg[i] <= HWDATA[eilo_pkg::PORT_POL_BIT];
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ctrl_reg <= eilo_pkg::CTRL_RST;
      svc_mask_reg <= eilo_pkg::SVC_MASK_RST;
    end else if (wr_hit) begin
      if (waddr_reg == eilo_pkg::A_CTRL) begin
        ctrl_reg <= {16'h0000, HWDATA[15:8], 6'h00, HWDATA[1:0]};
      end
      if (waddr_reg == eilo_pkg::A_SVC_MASK) begin
        svc_mask_reg <= HWDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bulb check after ignition turns on
  logic ign_d_reg;
  logic [31:0] bulb_cnt_reg;
  logic bulb;
  assign bulb = (bulb_cnt_reg != 32'h0000_0000);
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ign_d_reg <= 1'b0;
      bulb_cnt_reg <= 32'h0000_0000;
    end else begin
      ign_d_reg <= ign_s;
      if (ign_s && !ign_d_reg) begin
        bulb_cnt_reg <= BULB_CYC;  // RQ3
      end else if (bulb) begin
        bulb_cnt_reg <= bulb_cnt_reg - 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle lamp flasher; restarts dark whenever counting stops
  logic [31:0] half_cnt_reg;
  logic flash_reg;
  logic flash_run;
  logic idle_lamp;
  assign flash_run = idle_cnt_s && init_s && !idle_act_s;  // RQ10
  assign idle_lamp = idle_act_s || (flash_run && flash_reg);  // RQ11
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      half_cnt_reg <= 32'h0000_0000;
      flash_reg <= 1'b0;
    end else if (!flash_run) begin
      half_cnt_reg <= 32'h0000_0000;
      flash_reg <= 1'b0;
    end else if (half_cnt_reg == HALF_SEC_CYC - 1) begin
      half_cnt_reg <= 32'h0000_0000;
      flash_reg <= !flash_reg;  // RQ10
    end else begin
      half_cnt_reg <= half_cnt_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lamp conditions
  logic [eilo_pkg::COND_W-1:0] cond;
  logic cool_temp_hit, oil_temp_chk_hit, oil_temp_stop_hit;
  logic stop_cond, svc_cond, check_normal;
  logic [7:0] crit_sel;
  assign cool_temp_hit = cool_temp_s && !overtemp_protection_enable;  // RQ2
  assign oil_temp_chk_hit = oil_chk_s && overtemp_protection_enable;  // RQ5
  assign oil_temp_stop_hit = oil_stop_s && !overtemp_protection_enable;  // RQ6
  // protection lamps never see the service-now selection
  assign stop_cond = cool_temp_hit || crank_s || oil_temp_stop_hit || cool_press_s ||
                     oil_press_s || stop_fault_s;  // RQ15
  assign crit_sel = lamp_config_code[eilo_pkg::LCC_SUBSET_BIT] ? svc_mask_reg : 8'hFF;
  assign svc_cond = |(crit_s & crit_sel) || stop_cond;  // RQ13 RQ14
  assign check_normal = stop_cond || oil_temp_chk_hit || |crit_s;
  always_comb begin
    cond = '0;
    cond[eilo_pkg::C_COOL_TEMP] = bulb || cool_temp_hit;  // RQ2 RQ3
    cond[eilo_pkg::C_CRANK] = bulb || crank_s;  // RQ4
    cond[eilo_pkg::C_OIL_TEMP] = bulb || oil_temp_chk_hit || oil_temp_stop_hit;  // RQ5 RQ6
    cond[eilo_pkg::C_COOL_PRESS] = bulb || cool_press_s;  // RQ7
    cond[eilo_pkg::C_OIL_PRESS] = bulb || oil_press_s;  // RQ9
    cond[eilo_pkg::C_SUPPLY] = supply_s;  // RQ8
    cond[eilo_pkg::C_IDLE] = bulb || idle_lamp;  // RQ3 RQ11
    cond[eilo_pkg::C_GOV] = gov_s;  // RQ12
    cond[eilo_pkg::C_SVC] = svc_cond;  // RQ13
  end
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      CHECK_ENGINE_LAMP <= 1'b0;
      STOP_ENGINE_LAMP <= 1'b0;
      SERVICE_NOW_LAMP <= 1'b0;
    end else begin
      CHECK_ENGINE_LAMP <= bulb || (check_as_service ? svc_cond : check_normal);  // RQ16
      STOP_ENGINE_LAMP <= bulb || stop_cond;  // RQ3
      SERVICE_NOW_LAMP <= svc_cond;  // RQ14
    end
  end

  for (genvar g = 0; g < NP; g++) begin : g_port
    eilo_port_sel u_port (
      .clk(CLK),
      .rst_b(RST_B),
      .func(func_reg[g]),
      .invert(pol_reg[g]),
      .cond(cond),
      .gnd(PORT_GND[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky fault log, write one to clear; a new event beats the clear
  logic [eilo_pkg::LOG_W-1:0] log_set;
  logic [eilo_pkg::LOG_W-1:0] log_clr;
  logic idle_diag;
  always_comb begin
    idle_diag = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (func_reg[i] == eilo_pkg::FN_IDLE_LAMP && (open_s[i] || short_s[i])) begin
        idle_diag = 1'b1;  // RQ17
      end
    end
  end
  assign log_set = {idle_diag, supply_s, oil_press_s, cool_press_s,
                    oil_temp_chk_hit || oil_temp_stop_hit, crank_s, cool_temp_hit};  // RQ18
  assign log_clr = (wr_hit && waddr_reg == eilo_pkg::A_FAULT_LOG) ?
                   HWDATA[eilo_pkg::LOG_W-1:0] : '0;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      log_reg <= '0;
    end else begin
      log_reg <= (log_reg & ~log_clr) | log_set;  // RQ17 RQ18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_bulb_lamps;
    @(posedge CLK) disable iff (!RST_B)
      (ign_s && !ign_d_reg) |=> ##1 (CHECK_ENGINE_LAMP && STOP_ENGINE_LAMP);
  endproperty
  a_bulb_lamps: assert property (p_bulb_lamps) else $error("bulb check lamps missing"); // RQ3
  property p_cool_temp_stop;
    @(posedge CLK) disable iff (!RST_B)
      (cool_temp_s && !overtemp_protection_enable) |=> (STOP_ENGINE_LAMP && CHECK_ENGINE_LAMP);
  endproperty
  a_cool_temp_stop: assert property (p_cool_temp_stop) else $error("no stop lamp"); // RQ2
  property p_oil_check;
    @(posedge CLK) disable iff (!RST_B)
      (oil_chk_s && overtemp_protection_enable && !check_as_service) |=> CHECK_ENGINE_LAMP;
  endproperty
  a_oil_check: assert property (p_oil_check) else $error("oil temp check lamp off"); // RQ5
  property p_svc_stop;
    @(posedge CLK) disable iff (!RST_B)
      stop_fault_s |=> (SERVICE_NOW_LAMP && STOP_ENGINE_LAMP);
  endproperty
  a_svc_stop: assert property (p_svc_stop) else $error("service lamp off on stop fault"); // RQ14
  property p_flash_toggle;
    @(posedge CLK) disable iff (!RST_B)
      (flash_run && $past(flash_run) && half_cnt_reg == HALF_SEC_CYC - 1)
        |=> (flash_reg != $past(flash_reg));
  endproperty
  a_flash_toggle: assert property (p_flash_toggle) else $error("idle lamp missed toggle"); // RQ10
  property p_idle_steady;
    @(posedge CLK) disable iff (!RST_B)
      idle_act_s [*2] |-> idle_lamp && !flash_reg;
  endproperty
  a_idle_steady: assert property (p_idle_steady) else $error("idle lamp not steady"); // RQ11
  property p_log_supply;
    @(posedge CLK) disable iff (!RST_B)
      supply_s |=> log_reg[5];
  endproperty
  a_log_supply: assert property (p_log_supply) else $error("low supply not logged"); // RQ18
  property p_log_diag;
    @(posedge CLK) disable iff (!RST_B)
      idle_diag |=> log_reg[eilo_pkg::LOG_IDLE_DIAG];
  endproperty
  a_log_diag: assert property (p_log_diag) else $error("idle port fault not logged"); // RQ17

endmodule

/* File: verilog/eilo_pkg.sv */
// constants, register map and function decode for the indicator lamp outputs
package eilo_pkg;

  localparam int NUM_PORTS = 6;
  localparam int FUNC_W = 8;
  localparam int CRIT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // output function numbers
  localparam logic [7:0] FN_LOW_SUPPLY = 8'h03;
  localparam logic [7:0] FN_GOV_PRESS = 8'h05;
  localparam logic [7:0] FN_OIL_PRESS = 8'h12;
  localparam logic [7:0] FN_OIL_TEMP = 8'h13;
  localparam logic [7:0] FN_COOL_TEMP = 8'h14;
  localparam logic [7:0] FN_CRANK_PRESS = 8'h16;
  localparam logic [7:0] FN_COOL_PRESS = 8'h17;
  localparam logic [7:0] FN_IDLE_LAMP = 8'h1A;
  localparam logic [7:0] FN_SERVICE_NOW = 8'h2C;

  // condition vector positions
  localparam int C_COOL_TEMP = 0;
  localparam int C_CRANK = 1;
  localparam int C_OIL_TEMP = 2;
  localparam int C_COOL_PRESS = 3;
  localparam int C_OIL_PRESS = 4;
  localparam int C_SUPPLY = 5;
  localparam int C_IDLE = 6;
  localparam int C_GOV = 7;
  localparam int C_SVC = 8;
  localparam int COND_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [7:0] A_PORT0 = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h18;
  localparam logic [7:0] A_SVC_MASK = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_FAULT_LOG = 8'h24;
  localparam int PORT_POL_BIT = 8;
  localparam int CTRL_OVERTEMP_BIT = 0;
  localparam int CTRL_CHECK_AS_SVC_BIT = 1;
  localparam int CTRL_LCC_LSB = 8;
  localparam int LCC_SUBSET_BIT = 0;
  localparam int LOG_W = 7;
  localparam int LOG_IDLE_DIAG = 6;

  // reset values: default functions per port, all normal polarity
  localparam logic [47:0] PORT_FUNC_RST = {FN_IDLE_LAMP, FN_OIL_PRESS, FN_COOL_PRESS,
                                           FN_OIL_TEMP, FN_CRANK_PRESS, FN_COOL_TEMP};
  localparam logic [5:0] PORT_POL_RST = 6'h00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] SVC_MASK_RST = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned HALF_SEC_MS = 500;
  localparam int unsigned BULB_MS = 2000;
  localparam int unsigned HALF_SEC_CYC = HALF_SEC_MS * (CLK_HZ / 1000);
  localparam int unsigned BULB_CYC = BULB_MS * (CLK_HZ / 1000);

  function automatic logic [COND_W-1:0] eilo_func_onehot(input logic [7:0] fn);
    logic [COND_W-1:0] r;
    r = '0;
    unique case (fn)
      FN_COOL_TEMP: r[C_COOL_TEMP] = 1'b1;
      FN_CRANK_PRESS: r[C_CRANK] = 1'b1;
      FN_OIL_TEMP: r[C_OIL_TEMP] = 1'b1;
      FN_COOL_PRESS: r[C_COOL_PRESS] = 1'b1;
      FN_OIL_PRESS: r[C_OIL_PRESS] = 1'b1;
      FN_LOW_SUPPLY: r[C_SUPPLY] = 1'b1;
      FN_IDLE_LAMP: r[C_IDLE] = 1'b1;
      FN_GOV_PRESS: r[C_GOV] = 1'b1;
      FN_SERVICE_NOW: r[C_SVC] = 1'b1;
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

/* File: verilog/eilo_port_sel.sv */
// one low-side output port: function select and polarity
`timescale 1ns/1ps
module eilo_port_sel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] func,
  input wire logic invert,
  input wire logic [eilo_pkg::COND_W-1:0] cond,
  output logic gnd
);

  logic [eilo_pkg::COND_W-1:0] sel;
  logic known;
  logic gnd_next;

  assign sel = eilo_pkg::eilo_func_onehot(func);
  assign known = |sel;

  // unknown function stays open whatever the polarity
  always_comb begin
    gnd_next = 1'b0;
    if (known) begin  // RQ20
      gnd_next = (|(sel & cond)) ^ invert;  // RQ19
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gnd <= 1'b0;
    end else begin
      gnd <= gnd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_unknown_open;
    @(posedge clk) disable iff (!rst_b)
      (!known && $stable(func)) |=> !gnd;
  endproperty
  a_unknown_open: assert property (p_unknown_open) else $error("unknown func drives port"); // RQ20

  property p_invert_open;
    @(posedge clk) disable iff (!rst_b)
      (known && invert && |(sel & cond)) |=> !gnd;
  endproperty
  a_invert_open: assert property (p_invert_open) else $error("inverted port not open"); // RQ19

endmodule

/* File: test/eilo_lamp_model.sv */
// lamp and relay loads hung on the six low-side outputs
`timescale 1ns/1ps
module eilo_lamp_model (
  input wire logic [5:0] gnd,
  input wire logic [5:0] open_wire,
  input wire logic [5:0] short_batt,
  output logic [5:0] lit,
  output logic [5:0] sense_open,
  output logic [5:0] sense_short
);
  ////////////////////////////////////////////////////////////////////////////
  // a broken filament never lights, and an open load is seen whatever the switch does
  assign lit = gnd & ~open_wire;
  assign sense_open = open_wire;
  // a load shorted to battery only draws overcurrent once the switch closes
  assign sense_short = short_batt & gnd;
endmodule

/* File: test/eilo_top_tb_top.sv */
// register-level bench for the indicator lamp outputs
`timescale 1ns/1ps
module eilo_top_tb_top;
  localparam int HALF = 8;
  localparam int BULB = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [12:0] pins = 13'h0;
  logic [7:0] crit = 8'h00;
  logic [5:0] open_wire = 6'h00;
  logic [5:0] short_batt = 6'h00;
  logic [5:0] sense_open;
  logic [5:0] sense_short;
  logic [5:0] port_gnd;
  logic [5:0] lit;
  logic check_lamp;
  logic sel;
  logic svc_lamp;
  logic [31:0] obs;
  logic [31:0] r;
  int failures = 0;
  int n_checks = 0;
  int g;
  logic [7:0] dflt [6] = '{8'h14, 8'h16, 8'h13, 8'h17, 8'h12, 8'h1A};
  int stop_pin [5] = '{0, 1, 3, 4, 5};
  logic [12:0] fn_pin [3] = '{13'h0040, 13'h0800, 13'h1000};
  logic [7:0] fn_num [3] = '{eilo_pkg::FN_LOW_SUPPLY, eilo_pkg::FN_GOV_PRESS,
                             eilo_pkg::FN_SERVICE_NOW};

  assign obs = {23'h0, svc_lamp, sel, check_lamp, port_gnd};
  always #20 clk = ~clk;

  eilo_top #(.HALF_SEC_CYC(HALF), .BULB_CYC(BULB)) u_dut (
    .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .COOLANT_TEMP_STOP(pins[0]), .CRANK_PRESS_STOP(pins[1]), .OIL_TEMP_CHECK(pins[2]),
    .OIL_TEMP_STOP(pins[3]), .COOLANT_PRESS_STOP(pins[4]), .OIL_PRESS_STOP(pins[5]),
    .SUPPLY_LOW(pins[6]), .IGNITION_ON(pins[7]), .SYS_INIT_DONE(pins[8]),
    .IDLE_COUNTING(pins[9]), .IDLE_ACTIVE(pins[10]), .GOV_PRESS_MODE(pins[11]),
    .STOP_FAULT(pins[12]), .CRIT_FAULTS(crit), .PORT_OPEN(sense_open),
    .PORT_SHORT(sense_short), .PORT_GND(port_gnd), .CHECK_ENGINE_LAMP(check_lamp),
    .STOP_ENGINE_LAMP(sel), .SERVICE_NOW_LAMP(svc_lamp)
  );

  eilo_lamp_model u_lamps (
    .gnd(port_gnd), .open_wire(open_wire), .short_batt(short_batt),
    .lit(lit), .sense_open(sense_open), .sense_short(sense_short)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // entered just after a rising edge; returns just after the edge that saw ready
  task automatic wait_ready();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, {24'h0, a}, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, {24'h0, a}, 32'h0);
    chk(r, exp);
  endtask

  // pins pass two sync flops and the output flop, so five edges is settled
  task automatic drive(input logic [12:0] p, input logic [7:0] c);
    pins <= p;
    crit <= c;
    repeat (5) @(posedge clk);
  endtask

  // edges between two changes of port 5, bounded on both waits
  task automatic gap(output int n);
    logic v;
    int i;
    v = port_gnd[5];
    for (i = 0; i < 40 && port_gnd[5] === v; i++) @(posedge clk);
    v = port_gnd[5];
    for (n = 0; n < 40 && port_gnd[5] === v; n++) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 6; p++) begin
      rd_chk(eilo_pkg::A_PORT0 + 8'(4 * p), {24'h0, dflt[p]});
    end
    rd_chk(eilo_pkg::A_CTRL, 32'h0);
    rd_chk(eilo_pkg::A_SVC_MASK, 32'h0000_00FF);
    rd_chk(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset_values done");

    for (int k = 0; k < 5; k++) begin
      drive(13'h1 << stop_pin[k], 8'h00);
      chk(obs, 32'h1C0 | (32'h1 << k));
      drive(13'h0, 8'h00);
      chk(obs, 32'h0);
    end
    rd_chk(eilo_pkg::A_FAULT_LOG, 32'h0000_001F);
    wr(eilo_pkg::A_FAULT_LOG, 32'h0000_007F);
    rd_chk(eilo_pkg::A_FAULT_LOG, 32'h0);
    $display("test stop_conditions done");

    drive(13'h0004, 8'h00);
    chk(obs, 32'h0);
    wr(eilo_pkg::A_CTRL, 32'h0000_0001);
    drive(13'h0004, 8'h00);
    chk(obs, 32'h044);
    drive(13'h0005, 8'h00);
    chk({26'h0, port_gnd}, 32'h04);
    drive(13'h0, 8'h00);
    wr(eilo_pkg::A_CTRL, 32'h0);
    wr(eilo_pkg::A_FAULT_LOG, 32'h0000_007F);
    $display("test overtemp_protection done");

    for (int k = 0; k < 3; k++) begin
      wr(eilo_pkg::A_PORT0, {24'h0, fn_num[k]});
      drive(fn_pin[k], 8'h00);
      chk({26'h0, port_gnd}, 32'h01);
      drive(13'h0, 8'h00);
    end
    rd_chk(eilo_pkg::A_FAULT_LOG, 32'h0000_0020);
    wr(eilo_pkg::A_PORT0, 32'h0000_0103);
    drive(13'h0, 8'h00);
    chk({26'h0, port_gnd}, 32'h01);
    drive(13'h0040, 8'h00);
    chk({26'h0, port_gnd}, 32'h00);
    wr(eilo_pkg::A_PORT0, 32'h0000_0163);
    drive(13'h0, 8'h00);
    chk({26'h0, port_gnd}, 32'h00);
    $display("test function_select done");

    // subset enabled with only fault 0 in the mask
    wr(eilo_pkg::A_PORT0, {24'h0, eilo_pkg::FN_SERVICE_NOW});
    wr(eilo_pkg::A_CTRL, 32'h0000_0100);
    wr(eilo_pkg::A_SVC_MASK, 32'h0000_0001);
    drive(13'h0, 8'h02);
    chk(obs, 32'h040);
    drive(13'h0, 8'h01);
    chk(obs, 32'h141);
    wr(eilo_pkg::A_CTRL, 32'h0000_0102);
    drive(13'h0, 8'h02);
    chk(obs, 32'h0);
    drive(13'h1000, 8'h02);
    chk(obs, 32'h1C1);
    wr(eilo_pkg::A_CTRL, 32'h0);
    wr(eilo_pkg::A_PORT0, 32'h0000_0014);
    drive(13'h0, 8'h00);
    $display("test service_now done");

    drive(13'h0080, 8'h00);
    chk(obs & 32'h0FF, 32'h0FF);
    chk({26'h0, lit}, 32'h0000_003F);
    repeat (BULB) @(posedge clk);
    chk(obs & 32'h0FF, 32'h0);
    $display("test bulb_check done");

    drive(13'h0280, 8'h00);
    gap(g);
    chk(32'(g), 32'd40);
    drive(13'h0380, 8'h00);
    gap(g);
    chk(32'(g), 32'(HALF));
    drive(13'h0780, 8'h00);
    rd_chk(eilo_pkg::A_STATUS, 32'h0000_0780);
    gap(g);
    chk({31'h0, port_gnd[5]}, 32'h1);
    chk(32'(g), 32'd40);
    $display("test idle_lamp done");

    wr(eilo_pkg::A_FAULT_LOG, 32'h0000_007F);
    for (int k = 0; k < 2; k++) begin
      open_wire <= (k == 0) ? 6'h20 : 6'h00;
      short_batt <= (k == 1) ? 6'h20 : 6'h00;
      repeat (5) @(posedge clk);
      rd_chk(eilo_pkg::A_FAULT_LOG, 32'h0000_0040);
      open_wire <= 6'h00;
      short_batt <= 6'h00;
      repeat (5) @(posedge clk);
      wr(eilo_pkg::A_FAULT_LOG, 32'h0000_007F);
      rd_chk(eilo_pkg::A_FAULT_LOG, 32'h0);
    end
    $display("test port_diagnostics done");
    end_sim();
  end
endmodule
